// *** serial_link_pkg.sv ***
// Notes on behaviour
// - Software sets serializer pre-emphasis strength level.
// - Disabled link: reset, lanes powered down, gated.
// - Enabling releases link with current settings.
// - SYSREF event resets multiframe or multiblock counter.
// - Receiver must know transmitter counter phase.
// - Subclass 0: counter free-runs, SYSREF ignored.
// - 8B/10B: SYNC starts code sync, then alignment.
// - Six alarm sources are detected.
// - Alarm bits stick until host writes one.
// - Unmasked alarms reach the fault summary.
// - Status pin in alarm mode shows alarms.
// - Channel clock mismatch sets clock upset flag; the code sets it only while the link is enabled and both channels are on.
// - Leaving sleep may set clock upset flag.
// - Lane FIFO pointer upset sets lane flag.
// - Re-enabling the link reinitializes lane FIFOs.
package serial_link_pkg;
    localparam int NUM_LANES = 8;
    localparam int NUM_ALARMS = 6;
    localparam int ADDR_W = 12;
    localparam int PERIOD_W = 16;
    localparam int CLK_W = 4;

    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] ALARM_FLAGS_OFFSET = 12'h004;
    localparam logic [11:0] ALARM_MASK_OFFSET = 12'h008;
    localparam logic [11:0] LANE_FIFO_OFFSET = 12'h00c;
    localparam logic [11:0] STATUS_OFFSET = 12'h010;
    localparam logic [11:0] PERIOD_OFFSET = 12'h014;

    localparam int ALM_SAMPLE_PLL = 0;
    localparam int ALM_SERDES_PLL = 1;
    localparam int ALM_LINK_NOT_DATA = 2;
    localparam int ALM_SYSREF_REALIGN = 3;
    localparam int ALM_CLOCK_UPSET = 4;
    localparam int ALM_FIFO_ERROR = 5;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [5:0] MASK_RESET = 6'h00;
    localparam logic [15:0] PERIOD_RESET = 16'h0020;
    localparam logic [2:0] ILAS_MULTIFRAMES = 3'h4;
    // Pins start locked, no SYNC request, so reset raises no false alarm.
    localparam logic [4:0] PINS_IDLE = 5'h0e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {LINK_OFF, LINK_CGS, LINK_ILAS, LINK_DATA} link_state_t;

    // Control word, bit 0 upward: enable, pre-emphasis, subclass 1,
    // 64B/66B encoding, channel A off, channel B off, status pin select.
    typedef struct packed {
        logic status_pin_select;
        logic channel_b_off;
        logic channel_a_off;
        logic encoding_64b66b;
        logic subclass1;
        logic [3:0] pre_emphasis_level;
        logic link_enable;
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);

    // Asynchronous pins, synchronised together.
    typedef struct packed {
        logic sysref;
        logic sync_n;
        logic sample_pll_lock;
        logic serdes_pll_lock;
        logic global_sleep;
    } pins_t;

    function automatic logic [31:0] apply_strobe(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] merged;
        merged = old_word;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                merged[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return merged;
    endfunction
endpackage

// *** lmfc_timer.sv ***
`timescale 1ns/1ps
module lmfc_timer
    import serial_link_pkg::*;
(
    // Clock, reset and enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic subclass1,
    input wire logic sysref_event,
    input wire logic [PERIOD_W-1:0] period,
    // Timing outputs
    output logic lmfc_edge,
    output logic realign
);
    logic [PERIOD_W-1:0] cnt_r;
    logic realign_r;
    logic at_end;

    assign at_end = (cnt_r >= period - 16'h0001);
    assign lmfc_edge = run && (cnt_r == '0);
    assign realign = realign_r;

    // Without subclass 1 the counter free-runs at whatever phase it woke
    // up in, so several devices are not aligned to each other.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= '0;
        end
        else if (ce)
        begin
            if (!run)
            begin
                cnt_r <= '0;
            end
            else if (subclass1 && sysref_event)
            begin
                cnt_r <= '0;
            end
            else
            begin
                cnt_r <= at_end ? '0 : cnt_r + 16'h0001;
            end
        end
    end

    // A SYSREF that lands off the expected phase moves the internal clocks.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            realign_r <= 1'b0;
        end
        else if (ce)
        begin
            realign_r <= run && subclass1 && sysref_event && !at_end;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sysref_reset_a: assert property (
        ce && run && subclass1 && sysref_event |=> cnt_r == '0)
        else $error("SYSREF did not reset the multiframe counter");

    self_timed_a: assert property (
        ce && run && !subclass1 && !at_end |=> cnt_r == $past(cnt_r) + 1)
        else $error("Subclass 0 counter did not advance on its own");
endmodule // lmfc_timer

// *** serial_link_ctrl.sv ***
`timescale 1ns/1ps
module serial_link_ctrl
    import serial_link_pkg::*;
(
    // Clock, reset and enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Asynchronous pins
    input wire logic sysref_pin,
    input wire logic sync_n_pin,
    input wire logic sample_pll_lock,
    input wire logic serdes_pll_lock,
    input wire logic global_sleep_pin,
    // Same-clock monitors
    input wire logic [CLK_W-1:0] chan_a_clocks,
    input wire logic [CLK_W-1:0] chan_b_clocks,
    input wire logic [NUM_LANES-1:0] lane_fifo_upset,
    input wire logic calib_status,
    // Link control
    output logic link_rst_n,
    output logic link_clk_en,
    output logic [NUM_LANES-1:0] serializer_pd,
    output logic [3:0] pre_emphasis_level,
    output logic lmfc_edge,
    output logic fifo_reinit,
    output logic [1:0] link_state,
    // Status
    output logic calibration_state_pin,
    output logic fault_summary
);
    ctrl_t ctrl_r;
    logic [NUM_ALARMS-1:0] alarm_flags_r;
    logic [NUM_ALARMS-1:0] alarm_mask_bits_r;
    logic [NUM_LANES-1:0] lane_fifo_error_flags_r;
    logic [PERIOD_W-1:0] period_r;
    pins_t pin_meta_r;
    pins_t pin_sync_r;
    logic sysref_d_r;
    logic sleep_d_r;
    logic link_en_d_r;
    logic fifo_reinit_r;
    logic fault_r;
    logic cal_pin_r;
    link_state_t state_r;
    logic [2:0] ilas_cnt_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] ctrl_word;
    logic [31:0] wr_bits;
    logic [NUM_ALARMS-1:0] alarm_src;
    logic [NUM_ALARMS-1:0] alarm_clr;
    logic [NUM_LANES-1:0] lane_clr;
    logic sysref_event;
    logic realign;
    logic link_en;
    logic both_channels;
    logic sleep_exit;

    // Bus handshakes; a low clock enable stalls the AW, W and AR channels.
    assign awready = ce && !aw_held_r && !bvalid_r;
    assign wready = ce && !w_held_r && !bvalid_r;
    assign arready = ce && !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_addr = {awaddr_r[ADDR_W-1:2], 2'b00};
    assign rd_addr = {araddr[ADDR_W-1:2], 2'b00};
    assign ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl_r};
    assign wr_bits = apply_strobe(32'h0000_0000, wdata_r, wstrb_r);

    assign link_en = ctrl_r.link_enable;
    assign both_channels = !ctrl_r.channel_a_off && !ctrl_r.channel_b_off;
    assign sysref_event = pin_sync_r.sysref && !sysref_d_r;
    assign sleep_exit = sleep_d_r && !pin_sync_r.global_sleep;

    // The link sits in reset, unclocked and powered down while disabled.
    assign link_rst_n = link_en;
    assign link_clk_en = link_en;
    assign serializer_pd = {NUM_LANES{!link_en}};
    assign pre_emphasis_level = ctrl_r.pre_emphasis_level;
    assign fifo_reinit = fifo_reinit_r;
    assign link_state = 2'(state_r);
    assign fault_summary = fault_r;
    assign calibration_state_pin = cal_pin_r;

    // Write address and data may arrive in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            else if (wr_fire)
            begin
                aw_held_r <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            else if (wr_fire)
            begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                bvalid_r <= 1'b1;
                case (wr_addr)
                    CTRL_OFFSET, ALARM_FLAGS_OFFSET, ALARM_MASK_OFFSET,
                    LANE_FIFO_OFFSET, STATUS_OFFSET, PERIOD_OFFSET:
                        bresp_r <= RESP_OKAY;
                    default:
                        bresp_r <= RESP_SLVERR;
                endcase
            end
            else if (bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Writable configuration. Nothing stops software from touching it
    // while the link runs; changes then take effect mid-frame.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= ctrl_t'(CTRL_RESET[CTRL_W-1:0]);
            alarm_mask_bits_r <= MASK_RESET;
            period_r <= PERIOD_RESET;
        end
        else if (ce && wr_fire)
        begin
            if (wr_addr == CTRL_OFFSET)
            begin
                ctrl_r <= ctrl_t'(CTRL_W'(apply_strobe(ctrl_word, wdata_r,
                    wstrb_r)));
            end
            if (wr_addr == ALARM_MASK_OFFSET && wstrb_r[0])
            begin
                alarm_mask_bits_r <= wdata_r[NUM_ALARMS-1:0];
            end
            if (wr_addr == PERIOD_OFFSET)
            begin
                period_r <= 16'(apply_strobe({16'h0000, period_r}, wdata_r,
                    wstrb_r));
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                rvalid_r <= 1'b1;
                rresp_r <= RESP_OKAY;
                case (rd_addr)
                    CTRL_OFFSET: rdata_r <= ctrl_word;
                    ALARM_FLAGS_OFFSET:
                        rdata_r <= {26'h0, alarm_flags_r};
                    ALARM_MASK_OFFSET:
                        rdata_r <= {26'h0, alarm_mask_bits_r};
                    LANE_FIFO_OFFSET:
                        rdata_r <= {24'h0, lane_fifo_error_flags_r};
                    STATUS_OFFSET:
                        rdata_r <= {26'h0, pin_sync_r.serdes_pll_lock,
                            pin_sync_r.sample_pll_lock, !pin_sync_r.sync_n,
                            2'(state_r), fault_r};
                    PERIOD_OFFSET: rdata_r <= {16'h0000, period_r};
                    default:
                    begin
                        rdata_r <= 32'h0000_0000;
                        rresp_r <= RESP_SLVERR;
                    end
                endcase
            end
            else if (rready)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Pins are foreign to aclk; only the second stage is looked at.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_r <= pins_t'(PINS_IDLE);
            pin_sync_r <= pins_t'(PINS_IDLE);
            sysref_d_r <= 1'b0;
            sleep_d_r <= 1'b0;
        end
        else if (ce)
        begin
            pin_meta_r <= {sysref_pin, sync_n_pin, sample_pll_lock,
                serdes_pll_lock, global_sleep_pin};
            pin_sync_r <= pin_meta_r;
            sysref_d_r <= pin_sync_r.sysref;
            sleep_d_r <= pin_sync_r.global_sleep;
        end
    end

    lmfc_timer timer_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(link_en),
        .subclass1(ctrl_r.subclass1),
        .sysref_event(sysref_event),
        .period(period_r),
        .lmfc_edge(lmfc_edge),
        .realign(realign)
    );

    // Link start-up. 64B/66B has no code-group phase, so it goes straight
    // to data on the first multiblock edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= LINK_OFF;
            ilas_cnt_r <= '0;
        end
        else if (ce)
        begin
            case (state_r)
                LINK_OFF:
                    if (link_en)
                    begin
                        state_r <= LINK_CGS;
                    end
                LINK_CGS:
                    if (ctrl_r.encoding_64b66b)
                    begin
                        if (lmfc_edge)
                        begin
                            state_r <= LINK_DATA;
                        end
                    end
                    else if (pin_sync_r.sync_n && lmfc_edge)
                    begin
                        state_r <= LINK_ILAS;
                        ilas_cnt_r <= '0;
                    end
                LINK_ILAS:
                    if (lmfc_edge)
                    begin
                        ilas_cnt_r <= ilas_cnt_r + 3'h1;
                        if (ilas_cnt_r == ILAS_MULTIFRAMES - 3'h1)
                        begin
                            state_r <= LINK_DATA;
                        end
                    end
                LINK_DATA: ;
                default: state_r <= LINK_OFF;
            endcase
            if (!link_en)
            begin
                state_r <= LINK_OFF;
            end
            else if (state_r != LINK_OFF && !ctrl_r.encoding_64b66b &&
                !pin_sync_r.sync_n)
            begin
                state_r <= LINK_CGS;
            end
        end
    end

    // Alarm sources and host clears; a new event beats a clear.
    always_comb
    begin
        alarm_src = '0;
        alarm_src[ALM_SAMPLE_PLL] = !pin_sync_r.sample_pll_lock;
        alarm_src[ALM_SERDES_PLL] = link_en && !pin_sync_r.serdes_pll_lock;
        alarm_src[ALM_LINK_NOT_DATA] = link_en && state_r != LINK_DATA;
        alarm_src[ALM_SYSREF_REALIGN] = realign;
        alarm_src[ALM_CLOCK_UPSET] = (link_en && both_channels &&
            chan_a_clocks != chan_b_clocks) || sleep_exit;
        alarm_src[ALM_FIFO_ERROR] = link_en && |lane_fifo_upset;
        alarm_clr = (ce && wr_fire && wr_addr == ALARM_FLAGS_OFFSET) ?
            wr_bits[NUM_ALARMS-1:0] : '0;
        lane_clr = (ce && wr_fire && wr_addr == LANE_FIFO_OFFSET) ?
            wr_bits[NUM_LANES-1:0] : '0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_flags_r <= '0;
        end
        else if (ce)
        begin
            alarm_flags_r <= (alarm_flags_r & ~alarm_clr) | alarm_src;
        end
    end

    generate
        for (genvar l = 0; l < NUM_LANES; l++)
        begin : lane_g
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    lane_fifo_error_flags_r[l] <= 1'b0;
                end
                else if (ce)
                begin
                    lane_fifo_error_flags_r[l] <=
                        (lane_fifo_error_flags_r[l] && !lane_clr[l]) ||
                        (link_en && lane_fifo_upset[l]);
                end
            end
        end
    endgenerate

    // Summary and status pin lag the flags by one cycle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_r <= 1'b0;
            cal_pin_r <= 1'b0;
        end
        else if (ce)
        begin
            fault_r <= |(alarm_flags_r & ~alarm_mask_bits_r);
            cal_pin_r <= ctrl_r.status_pin_select ?
                |(alarm_flags_r & ~alarm_mask_bits_r) : calib_status;
        end
    end

    // A fresh enable restarts the lane FIFO pointers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            link_en_d_r <= 1'b0;
            fifo_reinit_r <= 1'b0;
        end
        else if (ce)
        begin
            link_en_d_r <= link_en;
            fifo_reinit_r <= link_en && !link_en_d_r;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    link_off_a: assert property (
        ce && wr_fire && wr_addr == CTRL_OFFSET && wstrb_r[0] && !wdata_r[0]
        |=> serializer_pd == '1 && !link_rst_n && !link_clk_en)
        else $error("Disabled link still powered or released");

    link_release_a: assert property (
        ce && wr_fire && wr_addr == CTRL_OFFSET && wstrb_r[0] && wdata_r[0]
        |=> link_rst_n && serializer_pd == '0)
        else $error("Enable write did not release the link");

    alarm_set_a: assert property (
        ce && alarm_src != '0
        |=> (alarm_flags_r & $past(alarm_src)) == $past(alarm_src))
        else $error("Alarm source did not set its flag");

    sticky_alarm_a: assert property (
        ce && (alarm_clr & alarm_flags_r) == '0
        |=> (alarm_flags_r & $past(alarm_flags_r)) == $past(alarm_flags_r))
        else $error("Alarm flag dropped without a host clear");

    fault_or_a: assert property (
        ce |=> fault_summary ==
        |($past(alarm_flags_r) & ~$past(alarm_mask_bits_r)))
        else $error("Fault summary differs from unmasked flags");

    status_pin_a: assert property (
        ce && ctrl_r.status_pin_select &&
        (alarm_flags_r & ~alarm_mask_bits_r) != '0
        |=> calibration_state_pin)
        else $error("Status pin low while an alarm is present");

    clock_upset_a: assert property (
        ce && link_en && both_channels && chan_a_clocks != chan_b_clocks
        |=> alarm_flags_r[ALM_CLOCK_UPSET])
        else $error("Channel clock mismatch not flagged");

    fifo_error_a: assert property (
        ce && link_en |=> (lane_fifo_error_flags_r &
        $past(lane_fifo_upset)) == $past(lane_fifo_upset))
        else $error("Lane FIFO upset not flagged");

    sequence reinit_pulse_s;
        fifo_reinit ##1 !fifo_reinit;
    endsequence

    fifo_reinit_a: assert property (
        ce && link_en && !link_en_d_r |=> reinit_pulse_s)
        else $error("Lane FIFOs not reinitialised once on enable");

    ilas_start_a: assert property (
        ce && state_r == LINK_CGS && link_en && !ctrl_r.encoding_64b66b &&
        pin_sync_r.sync_n && lmfc_edge |=> state_r == LINK_ILAS)
        else $error("Alignment sequence did not follow SYNC release");
endmodule // serial_link_ctrl

// *** link_receiver_model.sv ***
`timescale 1ns/1ps
module link_receiver_model
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link from the transmitter
    input wire logic link_rst_n,
    input wire logic lmfc_edge,
    // Receiver outputs
    output logic sync_n_pin,
    output logic release_r
);
    logic [1:0] seen_r;
    // SYNC stays low until the third multiframe edge so code sync can settle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !link_rst_n)
            seen_r <= 2'h0;
        else if (lmfc_edge && seen_r != 2'h3)
            seen_r <= seen_r + 2'h1;
    end
    assign sync_n_pin = (seen_r == 2'h3);
    // Release one cycle after the multiframe edge, once all lanes are in.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            release_r <= 1'b0;
        else
            release_r <= lmfc_edge && sync_n_pin;
    end
endmodule // link_receiver_model

// *** serial_link_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module serial_link_ctrl_tb_top
    import serial_link_pkg::*;
;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sysref_pin, sync_n_pin;
    logic sample_pll_lock, serdes_pll_lock, global_sleep_pin, calib_status;
    logic link_rst_n, link_clk_en, lmfc_edge, fifo_reinit;
    logic calibration_state_pin, fault_summary;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, pre_emphasis_level, chan_a_clocks, chan_b_clocks;
    logic [1:0] bresp, rresp, link_state, last_resp;
    logic [NUM_LANES-1:0] lane_fifo_upset, serializer_pd;
    int error_cnt, n_checks, reinit_cnt;
    int srcs[4] = '{ALM_SAMPLE_PLL, ALM_SERDES_PLL, ALM_CLOCK_UPSET,
        ALM_FIFO_ERROR};

    serial_link_ctrl u_serial_link_ctrl (.aclk(aclk), .aresetn(aresetn),
        .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .sysref_pin(sysref_pin),
        .sync_n_pin(sync_n_pin), .sample_pll_lock(sample_pll_lock),
        .serdes_pll_lock(serdes_pll_lock),
        .global_sleep_pin(global_sleep_pin), .chan_a_clocks(chan_a_clocks),
        .chan_b_clocks(chan_b_clocks), .lane_fifo_upset(lane_fifo_upset),
        .calib_status(calib_status), .link_rst_n(link_rst_n),
        .link_clk_en(link_clk_en), .serializer_pd(serializer_pd),
        .pre_emphasis_level(pre_emphasis_level), .lmfc_edge(lmfc_edge),
        .fifo_reinit(fifo_reinit), .link_state(link_state),
        .calibration_state_pin(calibration_state_pin),
        .fault_summary(fault_summary));
    link_receiver_model u_link_receiver_model (.aclk(aclk),
        .aresetn(aresetn), .link_rst_n(link_rst_n), .lmfc_edge(lmfc_edge),
        .sync_n_pin(sync_n_pin), .release_r());

    initial
    begin
        aclk = 1'b0;
        forever
            #2.5 aclk = ~aclk;
    end
    always @(posedge aclk)
        if (fifo_reinit === 1'b1)
            reinit_cnt++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Ready is judged mid-cycle, so the outcome never races the edge.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(negedge aclk);
            aw_done = aw_done || awready;
            w_done = w_done || wready;
            @(posedge aclk);
            if (aw_done)
                awvalid <= 1'b0;
            if (w_done)
                wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do
            @(negedge aclk);
        while (bvalid !== 1'b1);
        last_resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(negedge aclk);
        while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do
            @(negedge aclk);
        while (rvalid !== 1'b1);
        d = rdata;
        last_resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
        chk(d, exp);
    endtask
    task automatic cause(input int i, input logic v);
        case (i)
            ALM_SAMPLE_PLL: sample_pll_lock <= !v;
            ALM_SERDES_PLL: serdes_pll_lock <= !v;
            ALM_CLOCK_UPSET: chan_b_clocks <= v ? 4'h5 : 4'h0;
            default: lane_fifo_upset <= v ? 8'h08 : 8'h00;
        endcase
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #200us;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, sysref_pin} = 0;
        {global_sleep_pin, calib_status, awaddr, araddr, wdata} = 0;
        {chan_a_clocks, chan_b_clocks, lane_fifo_upset} = 0;
        {ce, sample_pll_lock, serdes_pll_lock} = 3'h7;
        wstrb = 4'hf;
        cyc(8);
        aresetn <= 1'b1;
        cyc(2);
        chk(32'(serializer_pd), 32'hff);
        chk(32'({link_rst_n, link_clk_en}), 32'h0);
        rc(CTRL_OFFSET, 32'h0);
        rc(PERIOD_OFFSET, 32'h20);
        rc(12'h040, 32'h0);
        chk(32'(last_resp), 32'(RESP_SLVERR));
        wr(PERIOD_OFFSET, 32'h4);
        wr(CTRL_OFFSET, 32'h13);
        cyc(3);
        chk(32'({link_rst_n, link_clk_en, serializer_pd}), 32'h300);
        chk(32'(pre_emphasis_level), 32'h9);
        chk(32'(reinit_cnt), 32'h1);
        for (int i = 0; i < 300 && link_state !== 2'h3; i++)
            @(posedge aclk);
        chk(32'(link_state), 32'h3);
        rc(ALARM_FLAGS_OFFSET, 32'h4);
        wr(ALARM_FLAGS_OFFSET, 32'h3f);
        foreach (srcs[k])
        begin
            cause(srcs[k], 1'b1);
            cyc(4);
            cause(srcs[k], 1'b0);
            cyc(6);
            chk(32'(fault_summary), 32'h1);
            rc(ALARM_FLAGS_OFFSET, 32'h1 << srcs[k]);
            wr(ALARM_FLAGS_OFFSET, 32'h1 << srcs[k]);
            rc(ALARM_FLAGS_OFFSET, 32'h0);
        end
        rc(LANE_FIFO_OFFSET, 32'h8);
        wr(LANE_FIFO_OFFSET, 32'h8);
        rc(LANE_FIFO_OFFSET, 32'h0);
        wr(ALARM_MASK_OFFSET, 32'h1);
        cause(ALM_SAMPLE_PLL, 1'b1);
        cyc(4);
        cause(ALM_SAMPLE_PLL, 1'b0);
        cyc(6);
        chk(32'(fault_summary), 32'h0);
        wr(CTRL_OFFSET, 32'h213);
        wr(ALARM_MASK_OFFSET, 32'h0);
        cyc(3);
        chk(32'({calibration_state_pin, fault_summary}), 32'h3);
        wr(ALARM_FLAGS_OFFSET, 32'h1);
        cyc(3);
        chk(32'(calibration_state_pin), 32'h0);
        global_sleep_pin <= 1'b1;
        cyc(4);
        global_sleep_pin <= 1'b0;
        cyc(8);
        rc(ALARM_FLAGS_OFFSET, 32'h10);
        wr(CTRL_OFFSET, 32'h72);
        wr(CTRL_OFFSET, 32'h73);
        do
            @(negedge aclk);
        while (lmfc_edge !== 1'b1);
        cyc(2);
        sysref_pin <= 1'b1;
        cyc(3);
        @(negedge aclk);
        chk(32'(lmfc_edge), 32'h1);
        cyc(1);
        sysref_pin <= 1'b0;
        chk(32'({link_state, reinit_cnt[3:0]}), 32'h32);
        rc(ALARM_FLAGS_OFFSET, 32'h1c);
        wr(CTRL_OFFSET, 32'h0);
        cyc(2);
        chk(32'({link_rst_n, link_state, serializer_pd}), 32'hff);
        report_and_stop();
    end
endmodule // serial_link_ctrl_tb_top
